/* File: core/mcrb_avg_decode.sv */
`timescale 1ns/1ps
module mcrb_avg_decode import mcrb_pkg::*; (
	input  wire logic [2:0] avg_sel,      // Averaging field
	output logic      [7:0] remote_count, // Averages, remote diodes
	output logic      [7:0] local_count   // Averages, internal and voltages
);

	// Top bit wins, then the middle bit
	function automatic logic [15:0] avg_pair(input logic [2:0] sel);
		logic [15:0] r;
		r = {AVG_N128, AVG_N8};
		if (sel[2]) begin
			r = {AVG_N32, AVG_N32};
		end else if (sel[1]) begin
			r = {AVG_N16, AVG_N16};
		end else if (sel[0]) begin
			r = {AVG_N16, AVG_N1};
		end
		return r;
	endfunction : avg_pair

	// Split the pair onto the two outputs
	always_comb begin
		{remote_count, local_count} = avg_pair(avg_sel);
	end

endmodule : mcrb_avg_decode

/* File: core/mcrb_pkg.sv */
// Contract
// - With the global lock set, writes to every register here are silently ignored.
// - Test-mode bit 0 enables the XOR tree; reset value zero; clearing restores normal.
// - XOR tree combines five voltage-id inputs, four tach inputs, fan drive pins 2 and 3.
// - Management bus data and clock stay out of the XOR tree.
// - Scratch registers 79h and 7Bh read/write, reset to zero; 7Ah read-only, mirrors readback input bits 6..0, bit 7 reads zero.
// - Mode bit 0 picks the low-power state: zero sleep, one shutdown.
// - Mode bit 1 picks monitoring: zero continuous, one power-saving cycle.
// - Mode bit 2 gates the alert pin function; zero disables, default.
// - Averaging field bits 7..5 decode with top bit first; top bit gives 32.
// - Codes 000, 001, 01x, 1xx give 128/8, 16/1, 16/16, 32/32 averages.
// - Averaging field resets to 010, so the mode register resets to 40h.
// - Voltage enable bits 2,3,5,6,7 gate each rail's status; bits 1,4 reserved.
// - Voltage enable bit 0 lets faults pull the alert low only with pin enable.
// - Config bit 0 routes fan_speed_in3 pin to alert; bit 1 routes fan_drive_out2 pin to alert.
// - Config bit 3 reports temperature readings valid after monitoring starts.
// - Config bit 4, set at reset, enables fan spin-up shortening.
// - Writing one to config bit 7 soft-resets all these registers; bit self-clears.
package mcrb_pkg;

	// Register offsets
	localparam logic [7:0] XOR_OFS  = 8'h6f;
	localparam logic [7:0] SCRA_OFS = 8'h79;
	localparam logic [7:0] RDBK_OFS = 8'h7a;
	localparam logic [7:0] SCRB_OFS = 8'h7b;
	localparam logic [7:0] MODE_OFS = 8'h7c;
	localparam logic [7:0] VEN_OFS  = 8'h7e;
	localparam logic [7:0] CFG_OFS  = 8'h7f;

	// Reset values
	localparam logic [7:0] XOR_RST  = 8'h00;
	localparam logic [7:0] SCR_RST  = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h40;
	localparam logic [7:0] VEN_RST  = 8'hec;
	localparam logic [7:0] CFG_RST  = 8'h10;

	// Field positions
	localparam int XOR_EN_BIT   = 0;
	localparam int MODE_LP_BIT  = 0;
	localparam int MODE_MON_BIT = 1;
	localparam int MODE_PIN_BIT = 2;
	localparam int MODE_AVG_LSB = 5;
	localparam int VEN_GRP_BIT  = 0;
	localparam int VEN_V25_BIT  = 2;
	localparam int VEN_VCP_BIT  = 3;
	localparam int VEN_V5_BIT   = 5;
	localparam int VEN_V12_BIT  = 6;
	localparam int VEN_VCC_BIT  = 7;
	localparam int CFG_T3_BIT   = 0;
	localparam int CFG_P2_BIT   = 1;
	localparam int CFG_TEMPERATURE_VALID_FLAG_BIT = 3;
	localparam int CFG_SUR_BIT  = 4;
	localparam int CFG_INIT_BIT = 7;

	// Writable and readable bit masks
	localparam logic [7:0] XOR_WMASK  = 8'h01;
	localparam logic [7:0] VEN_WMASK  = 8'hed;
	localparam logic [7:0] CFG_WMASK  = 8'h73;
	localparam logic [7:0] RDBK_MASK  = 8'h7f;

	// Averages per reading
	localparam logic [7:0] AVG_N1   = 8'h01;
	localparam logic [7:0] AVG_N8   = 8'h08;
	localparam logic [7:0] AVG_N16  = 8'h10;
	localparam logic [7:0] AVG_N32  = 8'h20;
	localparam logic [7:0] AVG_N128 = 8'h80;

	// Whole state of the register bank
	typedef struct packed {
		logic [7:0] xor_q;
		logic [7:0] scra;
		logic [7:0] scrb;
		logic [7:0] mode;
		logic [7:0] ven;
		logic [7:0] cfg;
		logic [7:0] rdata;
		logic       rvalid;
		logic       srst;
	} mcrb_state_t;

	localparam mcrb_state_t RST_STATE = '{
		xor_q: XOR_RST, scra: SCR_RST, scrb: SCR_RST, mode: MODE_RST,
		ven: VEN_RST, cfg: CFG_RST, rdata: 8'h00, rvalid: 1'b0, srst: 1'b0};

endpackage : mcrb_pkg

/* File: core/mcrb_regs.sv */
`timescale 1ns/1ps
module mcrb_regs import mcrb_pkg::*; (
	input  wire logic       clk,                      // System clock
	input  wire logic       rstn,                     // Async reset, active low
	input  wire logic [7:0] reg_addr,                 // Register offset
	input  wire logic       reg_wr_en,                // Write strobe
	input  wire logic [7:0] reg_wr_data,              // Write data
	input  wire logic       reg_rd_en,                // Read strobe
	output logic      [7:0] reg_rd_data,              // Read data, registered
	output logic            reg_rd_valid,             // Read data valid pulse
	input  wire logic       lock_active,              // Global lock bit
	input  wire logic       temp_ready_in,            // Temperature readings valid
	input  wire logic [7:0] test_readback_in,         // Readback test value
	input  wire logic [4:0] voltage_fault,            // 2.5V,Vccp,5V,12V,VCC faults
	output logic      [4:0] voltage_status_set,       // Gated status set requests
	output logic            alert_drive_low,          // Pull alert pin low
	input  wire logic [4:0] voltage_id_in,            // Voltage-id pins
	input  wire logic [3:0] fan_speed_in,             // Tach pins 1..4
	input  wire logic       fan_drive_out2_in,        // Fan drive pin 2 level
	input  wire logic       fan_drive_out3_in,        // Fan drive pin 3 level
	output logic            xor_tree_enable,          // Test mode active
	output logic            xor_tree_out,             // Test tree result
	output logic            low_power_select,         // 0 sleep, 1 shutdown
	output logic            monitor_mode_select,      // 0 continuous, 1 cycle
	output logic            alert_pin_enable,         // Alert pin function on
	output logic            spinup_shortening_enable, // Spin-up reduction on
	output logic            fan_speed_in3_pin_alert_select,   // Fan_speed_in3 pin carries alert
	output logic            fan_drive_out2_pin_alert_select,    // Fan_drive_out2 pin carries alert
	output logic      [7:0] remote_avg_count,         // Averages, remote diodes
	output logic      [7:0] local_avg_count,          // Averages, local channels
	output logic            soft_reset_pulse          // One-cycle soft reset
);

	////////////////////////////////////////////////////////////////////////
	// State

	mcrb_state_t s_q;
	mcrb_state_t s_d;
	logic        wr_ok;

	// A locked bank drops writes without any error indication
	assign wr_ok = reg_wr_en & ~lock_active;

	////////////////////////////////////////////////////////////////////////
	// Read multiplexer

	// Reserved rail-enable and test-mode bits read as zero; the soft reset bit never reads back set
	function automatic logic [7:0] read_mux(
		input mcrb_state_t st,
		input logic [7:0]  addr,
		input logic        temperature_valid_flag,
		input logic [7:0]  rdbk
	);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			XOR_OFS: begin
				v = st.xor_q;
			end
			SCRA_OFS: begin
				v = st.scra;
			end
			RDBK_OFS: begin
				v = rdbk & RDBK_MASK;
			end
			SCRB_OFS: begin
				v = st.scrb;
			end
			MODE_OFS: begin
				v = st.mode;
			end
			VEN_OFS: begin
				v = st.ven;
			end
			CFG_OFS: begin
				v = st.cfg;
				v[CFG_TEMPERATURE_VALID_FLAG_BIT] = temperature_valid_flag;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction : read_mux

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Read returns the value before a write in the same cycle
	always_comb begin
		s_d = s_q;
		s_d.srst = 1'b0;
		s_d.rvalid = 1'b0;
		if (reg_rd_en) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = read_mux(s_q, reg_addr, temp_ready_in, test_readback_in);
		end
		if (wr_ok) begin
			case (reg_addr)
				XOR_OFS: begin
					s_d.xor_q = reg_wr_data & XOR_WMASK;
				end
				SCRA_OFS: begin
					s_d.scra = reg_wr_data;
				end
				SCRB_OFS: begin
					s_d.scrb = reg_wr_data;
				end
				MODE_OFS: begin
					// Bits 3 and 4 kept as written; steering them is host's duty
					s_d.mode = reg_wr_data;
				end
				VEN_OFS: begin
					s_d.ven = reg_wr_data & VEN_WMASK;
				end
				CFG_OFS: begin
					if (reg_wr_data[CFG_INIT_BIT]) begin
						// Whole bank back to defaults; read path survives
						s_d = RST_STATE;
						s_d.rvalid = reg_rd_en;
						s_d.rdata = reg_rd_en ?
							read_mux(s_q, reg_addr, temp_ready_in, test_readback_in) :
							s_q.rdata;
						s_d.srst = 1'b1;
					end else begin
						// Bits 5 and 6 stored as written, left to the host
						s_d.cfg = reg_wr_data & CFG_WMASK;
					end
				end
				default: begin
					// Read-only and unmapped offsets drop the write
					s_d.xor_q = s_d.xor_q;
				end
			endcase
		end
	end

	// Bank state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Register fields straight to the pins
	assign reg_rd_data              = s_q.rdata;
	assign reg_rd_valid             = s_q.rvalid;
	assign soft_reset_pulse         = s_q.srst;
	assign xor_tree_enable          = s_q.xor_q[XOR_EN_BIT];
	assign low_power_select         = s_q.mode[MODE_LP_BIT];
	assign monitor_mode_select      = s_q.mode[MODE_MON_BIT];
	assign alert_pin_enable         = s_q.mode[MODE_PIN_BIT];
	assign spinup_shortening_enable = s_q.cfg[CFG_SUR_BIT];
	assign fan_speed_in3_pin_alert_select   = s_q.cfg[CFG_T3_BIT];
	assign fan_drive_out2_pin_alert_select    = s_q.cfg[CFG_P2_BIT];

	// Per-rail enables gate the status set; kept combinational so no event slips
	assign voltage_status_set[0] = voltage_fault[0] & s_q.ven[VEN_V25_BIT];
	assign voltage_status_set[1] = voltage_fault[1] & s_q.ven[VEN_VCP_BIT];
	assign voltage_status_set[2] = voltage_fault[2] & s_q.ven[VEN_V5_BIT];
	assign voltage_status_set[3] = voltage_fault[3] & s_q.ven[VEN_V12_BIT];
	assign voltage_status_set[4] = voltage_fault[4] & s_q.ven[VEN_VCC_BIT];

	// Alert pull needs group enable and pin function both on
	assign alert_drive_low = alert_pin_enable & s_q.ven[VEN_GRP_BIT]
		& (|voltage_fault);

	////////////////////////////////////////////////////////////////////////
	// Submodules

	// Bus pins are not wired in, so the host stays usable in test mode
	mcrb_xor_tree u_xor (
		.enable    (xor_tree_enable),
		.vid_in    (voltage_id_in),
		.tach_in   (fan_speed_in),
		.drive2_in (fan_drive_out2_in),
		.drive3_in (fan_drive_out3_in),
		.tree_out  (xor_tree_out)
	);

	// Averaging counts for the monitor sequencer
	mcrb_avg_decode u_avg (
		.avg_sel      (s_q.mode[MODE_AVG_LSB +: 3]),
		.remote_count (remote_avg_count),
		.local_count  (local_avg_count)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	// Locked writes leave every register untouched
	AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!rstn)
		(reg_wr_en && lock_active) |=>
		(s_q.xor_q == $past(s_q.xor_q) && s_q.mode == $past(s_q.mode)
		&& s_q.ven == $past(s_q.ven) && s_q.cfg == $past(s_q.cfg)
		&& s_q.scra == $past(s_q.scra) && s_q.scrb == $past(s_q.scrb)
		&& !soft_reset_pulse))
		else $error("locked write changed a register");

	// Test mode follows the written bit
	AST_XEN_SET: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == XOR_OFS) |=>
		(xor_tree_enable == $past(reg_wr_data[XOR_EN_BIT])))
		else $error("test mode bit not taken");

	// Tree output is parity of the eleven pins
	AST_XOR_PARITY: assert property (@(posedge clk) disable iff (!rstn)
		xor_tree_enable |->
		(xor_tree_out == ^{voltage_id_in, fan_speed_in,
		fan_drive_out2_in, fan_drive_out3_in}))
		else $error("xor tree parity wrong");

	// Read-only test register mirrors the low seven bits of its source
	AST_RDBK_RO: assert property (@(posedge clk) disable iff (!rstn)
		(reg_rd_en && reg_addr == RDBK_OFS) |=>
		(reg_rd_valid && reg_rd_data == ($past(test_readback_in) & RDBK_MASK)))
		else $error("readback register wrong");

	// Mode bits follow a write
	AST_MODE_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == MODE_OFS) |=>
		(low_power_select == $past(reg_wr_data[MODE_LP_BIT])
		&& monitor_mode_select == $past(reg_wr_data[MODE_MON_BIT])
		&& alert_pin_enable == $past(reg_wr_data[MODE_PIN_BIT])))
		else $error("mode bits not taken");

	// Top averaging bit forces 32 everywhere
	AST_AVG_PRIO: assert property (@(posedge clk) disable iff (!rstn)
		s_q.mode[MODE_AVG_LSB + 2] |->
		(remote_avg_count == AVG_N32 && local_avg_count == AVG_N32))
		else $error("averaging priority wrong");

	// Zero code gives the long remote averaging
	AST_AVG_ZERO: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.mode[MODE_AVG_LSB +: 3] == 3'h0) |->
		(remote_avg_count == AVG_N128 && local_avg_count == AVG_N8))
		else $error("averaging code 000 wrong");

	// Status set only where enabled
	AST_STATUS_GATE: assert property (@(posedge clk) disable iff (!rstn)
		(voltage_status_set & ~{s_q.ven[VEN_VCC_BIT], s_q.ven[VEN_V12_BIT],
		s_q.ven[VEN_V5_BIT], s_q.ven[VEN_VCP_BIT], s_q.ven[VEN_V25_BIT]}) == 5'h00)
		else $error("status set while disabled");

	// Alert pull tied to its three causes
	AST_ALERT: assert property (@(posedge clk) disable iff (!rstn)
		alert_drive_low == (alert_pin_enable && s_q.ven[VEN_GRP_BIT]
		&& voltage_fault != 5'h00))
		else $error("alert pull mismatch");

	// Config read carries the ready input and never the init bit
	AST_TEMPERATURE_VALID_FLAG_READ: assert property (@(posedge clk) disable iff (!rstn)
		(reg_rd_en && reg_addr == CFG_OFS) |=>
		(reg_rd_data[CFG_TEMPERATURE_VALID_FLAG_BIT] == $past(temp_ready_in)
		&& !reg_rd_data[CFG_INIT_BIT]))
		else $error("config readback wrong");

	// Soft reset restores defaults for exactly one pulse
	AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == CFG_OFS && reg_wr_data[CFG_INIT_BIT]) |=>
		(soft_reset_pulse && s_q.mode == MODE_RST && s_q.cfg == CFG_RST
		&& s_q.ven == VEN_RST && s_q.xor_q == XOR_RST)
		##1 (!soft_reset_pulse
		|| $past(wr_ok && reg_addr == CFG_OFS && reg_wr_data[CFG_INIT_BIT])))
		else $error("soft reset did not restore defaults");

	// Tree output rests low outside test mode
	AST_TREE_OFF: assert property (@(posedge clk) disable iff (!rstn)
		!xor_tree_enable |-> !xor_tree_out)
		else $error("xor tree active outside test mode");

	// Reserved test-mode bits never hold a one
	AST_XOR_RESERVED: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.xor_q & ~XOR_WMASK) == 8'h00)
		else $error("reserved test bit set");

	// First scratch register takes the whole byte
	AST_SCRA_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == SCRA_OFS) |=> (s_q.scra == $past(reg_wr_data)))
		else $error("scratch a not written");

	// Second scratch register takes the whole byte
	AST_SCRB_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == SCRB_OFS) |=> (s_q.scrb == $past(reg_wr_data)))
		else $error("scratch b not written");

	// Writes to the readback offset land nowhere
	AST_RDBK_NO_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(reg_wr_en && reg_addr == RDBK_OFS) |=>
		($stable(s_q.xor_q) && $stable(s_q.scra) && $stable(s_q.scrb)
		&& $stable(s_q.mode) && $stable(s_q.ven) && $stable(s_q.cfg)))
		else $error("readback write changed a register");

	// Mode byte stored as written, reserved pair included
	AST_MODE_BYTE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == MODE_OFS) |=>
		(s_q.mode == $past(reg_wr_data)))
		else $error("mode byte not stored");

	// Pin function off means no alert pull
	AST_PIN_GATE: assert property (@(posedge clk) disable iff (!rstn)
		!alert_pin_enable |-> !alert_drive_low)
		else $error("alert pulled with pin function off");

	// Code 001 gives short remote averaging and none locally
	AST_AVG_ONE: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.mode[MODE_AVG_LSB +: 3] == 3'h1) |->
		(remote_avg_count == AVG_N16 && local_avg_count == AVG_N1))
		else $error("averaging code 001 wrong");

	// Codes 010 and 011 give 16 everywhere
	AST_AVG_MID: assert property (@(posedge clk) disable iff (!rstn)
		(!s_q.mode[MODE_AVG_LSB + 2] && s_q.mode[MODE_AVG_LSB + 1]) |->
		(remote_avg_count == AVG_N16 && local_avg_count == AVG_N16))
		else $error("averaging code 01x wrong");

	// Reserved rail enable bits never hold a one
	AST_VEN_RESERVED: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.ven & ~VEN_WMASK) == 8'h00)
		else $error("reserved rail enable bit set");

	// Rail enables follow a write, reserved bits dropped
	AST_VEN_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == VEN_OFS) |=>
		(s_q.ven == ($past(reg_wr_data) & VEN_WMASK)))
		else $error("rail enables not stored");

	// Pin selects and spin-up bit follow a plain config write
	AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == CFG_OFS && !reg_wr_data[CFG_INIT_BIT]) |=>
		(fan_speed_in3_pin_alert_select == $past(reg_wr_data[CFG_T3_BIT])
		&& fan_drive_out2_pin_alert_select == $past(reg_wr_data[CFG_P2_BIT])
		&& spinup_shortening_enable == $past(reg_wr_data[CFG_SUR_BIT])))
		else $error("config bits not taken");

	// First edge after a hard reset still shows the reset image
	AST_RESET_IMAGE: assert property (@(posedge clk) disable iff (!rstn)
		!$past(rstn) |->
		(s_q == RST_STATE))
		else $error("reset image wrong");

	// The init bit is never stored
	AST_INIT_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
		!s_q.cfg[CFG_INIT_BIT])
		else $error("init bit stored");

	// Soft reset clears the scratch pair too
	AST_SCR_SRST: assert property (@(posedge clk) disable iff (!rstn)
		(wr_ok && reg_addr == CFG_OFS && reg_wr_data[CFG_INIT_BIT]) |=>
		(s_q.scra == SCR_RST && s_q.scrb == SCR_RST))
		else $error("soft reset left scratch data");

	// No soft reset pulse without an accepted init write
	AST_SRST_CAUSE: assert property (@(posedge clk) disable iff (!rstn)
		soft_reset_pulse |->
		$past(wr_ok && reg_addr == CFG_OFS && reg_wr_data[CFG_INIT_BIT]))
		else $error("soft reset pulse without cause");

endmodule : mcrb_regs

/* File: core/mcrb_xor_tree.sv */
`timescale 1ns/1ps
module mcrb_xor_tree (
	input  wire logic       enable,     // Test mode active
	input  wire logic [4:0] vid_in,     // Voltage-id pins
	input  wire logic [3:0] tach_in,    // Tach pins 1..4
	input  wire logic       drive2_in,  // Fan drive pin 2 level
	input  wire logic       drive3_in,  // Fan drive pin 3 level
	output logic            tree_out    // Parity of all tree pins
);

	// Parity is order-independent, so one reduction covers the chain
	always_comb begin
		tree_out = 1'b0;
		if (enable) begin
			tree_out = ^{vid_in, tach_in, drive2_in, drive3_in};
		end
	end

endmodule : mcrb_xor_tree

/* File: verif/mcrb_host_model.sv */
`timescale 1ns/1ps
module mcrb_host_model import mcrb_pkg::*; (
	input  wire logic       clk,          // System clock
	input  wire logic [7:0] reg_rd_data,  // Read data from bank
	input  wire logic       reg_rd_valid, // Read data valid
	output logic      [7:0] reg_addr,     // Register offset
	output logic            reg_wr_en,    // Write strobe
	output logic      [7:0] reg_wr_data,  // Write data
	output logic            reg_rd_en     // Read strobe
);
	// Idle bus from time zero
	initial begin
		reg_addr    = 8'h00;
		reg_wr_en   = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en   = 1'b0;
	end

	// One-cycle write; reserved mode and config bits kept at their safe values
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == MODE_OFS) v[4:3] = 2'b00;
		if (a == CFG_OFS) v[6:5] = 2'b00;
		@(negedge clk);
		reg_addr    = a;
		reg_wr_data = v;
		reg_wr_en   = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask : write_reg

	// One-cycle read; answer sampled a cycle after the strobe edge
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		reg_addr  = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		d = reg_rd_data;
		v = reg_rd_valid;
	endtask : read_reg
endmodule : mcrb_host_model

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench import mcrb_pkg::*;;
	logic clk, rstn, lock_active, temp_ready_in, fan_drive_out2_in, fan_drive_out3_in;
	logic [7:0] test_readback_in, reg_addr, reg_wr_data, reg_rd_data;
	logic [7:0] remote_avg_count, local_avg_count;
	logic [4:0] voltage_fault, voltage_status_set, voltage_id_in;
	logic [3:0] fan_speed_in;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, alert_drive_low, xor_tree_enable, xor_tree_out;
	logic low_power_select, monitor_mode_select, alert_pin_enable, spinup_shortening_enable;
	logic fan_speed_in3_pin_alert_select, fan_drive_out2_pin_alert_select, soft_reset_pulse;
	int   n_errors = 0;
	int   n_checks = 0;

	mcrb_regs u_mcrb_regs (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .lock_active(lock_active),
		.temp_ready_in(temp_ready_in), .test_readback_in(test_readback_in),
		.voltage_fault(voltage_fault), .voltage_status_set(voltage_status_set),
		.alert_drive_low(alert_drive_low), .voltage_id_in(voltage_id_in),
		.fan_speed_in(fan_speed_in), .fan_drive_out2_in(fan_drive_out2_in),
		.fan_drive_out3_in(fan_drive_out3_in), .xor_tree_enable(xor_tree_enable),
		.xor_tree_out(xor_tree_out), .low_power_select(low_power_select),
		.monitor_mode_select(monitor_mode_select), .alert_pin_enable(alert_pin_enable),
		.spinup_shortening_enable(spinup_shortening_enable),
		.fan_speed_in3_pin_alert_select(fan_speed_in3_pin_alert_select),
		.fan_drive_out2_pin_alert_select(fan_drive_out2_pin_alert_select), .remote_avg_count(remote_avg_count),
		.local_avg_count(local_avg_count), .soft_reset_pulse(soft_reset_pulse));

	mcrb_host_model u_mcrb_host_model (.clk(clk), .reg_rd_data(reg_rd_data),
		.reg_rd_valid(reg_rd_valid), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));

	////////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, far beyond the 140 or so cycles the tests need
	initial begin
		#200us;
		n_errors++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_mcrb_host_model.write_reg(a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		u_mcrb_host_model.read_reg(a, d, v);
		chk("rd_valid", 8'h01, {7'h00, v});
		chk("rd_data", e, d);
	endtask : rd

	// Expected averages, remote then local; top field bit wins
	function automatic logic [15:0] avg_exp(input logic [2:0] c);
		if (c[2]) return {8'h20, 8'h20};
		else if (c[1]) return {8'h10, 8'h10};
		else if (c[0]) return {8'h10, 8'h01};
		else return {8'h80, 8'h08};
	endfunction : avg_exp

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0]  w;
		logic [15:0] ex;
		rstn = 1'b0;
		lock_active = 1'b0;
		temp_ready_in = 1'b0;
		test_readback_in = 8'hff;
		voltage_fault = 5'h00;
		{voltage_id_in, fan_speed_in, fan_drive_out2_in, fan_drive_out3_in} = 11'h000;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		// Reset image, unmapped offset reads zero
		rd(XOR_OFS, 8'h00);
		rd(SCRA_OFS, 8'h00);
		rd(RDBK_OFS, 8'h7f);
		rd(SCRB_OFS, 8'h00);
		rd(MODE_OFS, 8'h40);
		rd(VEN_OFS, 8'hec);
		rd(CFG_OFS, 8'h10);
		rd(8'h7d, 8'h00);
		chk("spinup", 8'h01, {7'h00, spinup_shortening_enable});
		chk("remote_avg", 8'h10, remote_avg_count);
		// Every averaging code with the low mode bits
		for (int c = 0; c < 8; c++) begin
			w = {c[2:0], 2'b00, c[2:0]};
			wr(MODE_OFS, w);
			rd(MODE_OFS, w);
			ex = avg_exp(c[2:0]);
			chk("remote_avg", ex[15:8], remote_avg_count);
			chk("local_avg", ex[7:0], local_avg_count);
			chk("low_power", {7'h00, w[0]}, {7'h00, low_power_select});
			chk("monitor", {7'h00, w[1]}, {7'h00, monitor_mode_select});
			chk("pin_en", {7'h00, w[2]}, {7'h00, alert_pin_enable});
		end
		// Rail enables and the group alert gate
		voltage_fault = 5'h1f;
		wr(VEN_OFS, 8'hff);
		rd(VEN_OFS, 8'hed);
		chk("status", 8'h1f, {3'h0, voltage_status_set});
		chk("alert", 8'h01, {7'h00, alert_drive_low});
		wr(VEN_OFS, 8'ha4);
		chk("status", 8'h15, {3'h0, voltage_status_set});
		chk("alert", 8'h00, {7'h00, alert_drive_low});
		wr(VEN_OFS, 8'h49);
		chk("status", 8'h0a, {3'h0, voltage_status_set});
		chk("alert", 8'h01, {7'h00, alert_drive_low});
		wr(MODE_OFS, 8'h40);
		chk("alert", 8'h00, {7'h00, alert_drive_low});
		// Test tree: each pin alone must flip the result
		wr(XOR_OFS, 8'hff);
		rd(XOR_OFS, 8'h01);
		chk("xor_en", 8'h01, {7'h00, xor_tree_enable});
		for (int i = 0; i < 11; i++) begin
			@(negedge clk);
			{voltage_id_in, fan_speed_in, fan_drive_out2_in, fan_drive_out3_in} = 11'h001 << i;
			#1;
			chk("xor_out", 8'h01, {7'h00, xor_tree_out});
		end
		wr(XOR_OFS, 8'h00);
		chk("xor_en", 8'h00, {7'h00, xor_tree_enable});
		chk("xor_out", 8'h00, {7'h00, xor_tree_out});
		// Pin selects, ready flag, spin-up
		temp_ready_in = 1'b1;
		wr(CFG_OFS, 8'h03);
		rd(CFG_OFS, 8'h0b);
		chk("t3_sel", 8'h01, {7'h00, fan_speed_in3_pin_alert_select});
		chk("p2_sel", 8'h01, {7'h00, fan_drive_out2_pin_alert_select});
		chk("spinup", 8'h00, {7'h00, spinup_shortening_enable});
		wr(CFG_OFS, 8'h12);
		rd(CFG_OFS, 8'h1a);
		chk("t3_sel", 8'h00, {7'h00, fan_speed_in3_pin_alert_select});
		// Scratch pair, read-only readback, unmapped write
		wr(SCRA_OFS, 8'ha5);
		wr(SCRB_OFS, 8'h5a);
		wr(RDBK_OFS, 8'h33);
		wr(8'h7d, 8'hff);
		test_readback_in = 8'h80;
		rd(SCRA_OFS, 8'ha5);
		rd(SCRB_OFS, 8'h5a);
		rd(RDBK_OFS, 8'h00);
		rd(8'h7d, 8'h00);
		// Locked: writes and soft reset dropped
		lock_active = 1'b1;
		wr(MODE_OFS, 8'he7);
		wr(SCRA_OFS, 8'h00);
		wr(XOR_OFS, 8'h01);
		wr(CFG_OFS, 8'h80);
		wr(VEN_OFS, 8'h00);
		rd(MODE_OFS, 8'h40);
		rd(SCRA_OFS, 8'ha5);
		rd(XOR_OFS, 8'h00);
		rd(CFG_OFS, 8'h1a);
		rd(VEN_OFS, 8'h49);
		lock_active = 1'b0;
		// Soft reset restores defaults and self-clears
		wr(XOR_OFS, 8'h01);
		wr(MODE_OFS, 8'he7);
		wr(CFG_OFS, 8'h80);
		chk("srst", 8'h01, {7'h00, soft_reset_pulse});
		rd(CFG_OFS, 8'h18);
		chk("srst", 8'h00, {7'h00, soft_reset_pulse});
		rd(MODE_OFS, 8'h40);
		rd(SCRA_OFS, 8'h00);
		rd(SCRB_OFS, 8'h00);
		rd(VEN_OFS, 8'hec);
		rd(XOR_OFS, 8'h00);
		chk("spinup", 8'h01, {7'h00, spinup_shortening_enable});
		end_of_test();
	end
endmodule : testbench
